// ==== cer_defs.vh ====
// Constants for the completion error reporting block.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef CER_DEFS_VH
`define CER_DEFS_VH

// Error report vector bit positions
`define CER_BIT_CTO_COR     0
`define CER_BIT_CTO_UNC     1
`define CER_BIT_CA          2
`define CER_BIT_UC          3
`define CER_BIT_UR_POSTED   4
`define CER_BIT_UR_NP       5
`define CER_BIT_LOG_HDR     6
`define CER_VEC_W           7
`define CER_NUM_CLASS       6

// Header log width
`define CER_HDR_W           128

// Message codes for the transmit request
`define CER_MSG_W           2
`define CER_MSG_COR         2'h0
`define CER_MSG_NONFATAL    2'h1
`define CER_MSG_FATAL       2'h2

// Status bit positions in the status output
`define CER_ST_W            7
`define CER_ST_CED          0
`define CER_ST_NFED         1
`define CER_ST_FED          2
`define CER_ST_URD          3
`define CER_ST_CTO          4
`define CER_ST_CA           5
`define CER_ST_UC           6

// Pending counter width per error class
`define CER_CNT_W           4
`define CER_CNT_ZERO        4'h0
`define CER_CNT_ONE         4'h1
`define CER_CNT_MAX         4'hF

`endif

// ==== cer_pend.v ====
// Per-class pending event counter for the error message queue.
// Assumes one-cycle event pulses and a one-cycle take pulse from the arbiter.
`timescale 1ns/1ps
`default_nettype none
`include "cer_defs.vh"

module cer_pend (
	input  wire                  clk_sys,  // System clock
	input  wire                  rst,      // Sync reset, active high
	input  wire                  event_in, // New error event pulse
	input  wire                  take,     // Arbiter consumes one event
	output wire                  pending,  // At least one event waiting
	output reg                   overflow  // Sticky: an event was dropped
);

	reg [`CER_CNT_W-1:0] count;

	assign pending = (count != `CER_CNT_ZERO);

	// Count up and down at once when both arrive, so no event is lost
	always @(posedge clk_sys) begin
		if (rst) begin
			count    <= `CER_CNT_ZERO;
			overflow <= 1'b0;
		end else begin
			if (event_in && !(take && pending)) begin
				if (count == `CER_CNT_MAX)
					overflow <= 1'b1;  // Saturate rather than wrap
				else
					count <= count + `CER_CNT_ONE;
			end else if (!event_in && take && pending) begin
				count <= count - `CER_CNT_ONE;
			end
		end
	end

endmodule // cer_pend

`default_nettype wire

// ==== cer_top.v ====
// Completion error sideband: turns application error pulses into status bits,
// queued error messages and a first-error header log.
// Assumes the application drives report bits synchronous to clk_sys, and the
// message sink answers msg_valid with msg_ready.
//
// Contract
// R1: Application pulses each detected error bit for exactly one cycle.
// R2: Several errors, even in one cycle, are all logged; code merges same-class application and internal reports in one cycle.
// R3: Application pulses bit 0 on correctable 50 ms completion timeout.
// R4: Bit 0 makes the device send an advisory error message.
// R5: Application pulses bit 1 on uncorrectable 50 ms completion timeout.
// R6: Bit 1 makes the device send a non-advisory error message.
// R7: Application pulses bit 2 on completer abort for any request.
// R8: For non-posted abort, application sends CA completion before pulsing bit 2.
// R9: Application pulses bit 3 when a master sees unexpected completion.
// R10: Application pulses bit 4 for posted unsupported request, no completion.
// R11: Non-posted unsupported request: application sends UR completion, pulses bit 5.
// R12: Device sets config status bits and sends required error messages.
// R13: Application builds completions itself; device never sends them.
// R14: Device's own transaction layer also reports UC and UR cases.
// R15: Header-log bit 6 accompanies one of bits 2 to 5 in-cycle.
// R16: Bit 6 logs the 128-bit header only for the first error.
// R17: Report bits sampled on rising clock; one high cycle is one event.
`timescale 1ns/1ps
`default_nettype none
`include "cer_defs.vh"

module cer_top (
	input  wire                    clk_sys,          // System clock, 100 MHz
	input  wire                    rst,              // Sync reset, active high
	input  wire [`CER_VEC_W-1:0]   cpl_err_report,   // Application error pulses
	input  wire [`CER_HDR_W-1:0]   error_header_descriptor, // Header to log
	input  wire                    tl_uc_detect,     // Internal unexpected completion
	input  wire                    tl_ur_posted,     // Internal posted UR
	input  wire                    tl_ur_np,         // Internal non-posted UR
	input  wire                    advisory_nf_en,   // Treat CA/UC/non-posted UR as advisory
	input  wire                    cto_unc_fatal,    // Uncorrectable timeout is fatal
	input  wire                    ur_report_en,     // Device control UR reporting
	input  wire                    cor_report_en,    // Device control correctable enable
	input  wire                    nf_report_en,     // Device control non-fatal enable
	input  wire                    fatal_report_en,  // Device control fatal enable
	input  wire                    status_clear,     // Pulse: clear status bits
	input  wire [`CER_ST_W-1:0]    status_clear_mask, // Which status bits to clear
	input  wire                    hdr_log_release,  // Pulse: rearm header log
	input  wire                    msg_ready,        // Message sink takes message
	output wire                    msg_valid,        // Error message waiting
	output reg  [`CER_MSG_W-1:0]   msg_code,         // Message kind
	output reg  [`CER_ST_W-1:0]    err_status,       // Config space status bits
	output reg  [`CER_HDR_W-1:0]   hdr_log,          // Logged header
	output reg                     hdr_log_valid,    // Header log holds first error
	output wire                    queue_overflow    // Sticky: events dropped
);

	// Source indices for the pending counters; the lowest index is served first
	localparam SRC_CTO_COR = `CER_BIT_CTO_COR;
	localparam SRC_CTO_UNC = `CER_BIT_CTO_UNC;
	localparam SRC_CA      = `CER_BIT_CA;
	localparam SRC_UC      = `CER_BIT_UC;
	localparam SRC_UR_P    = `CER_BIT_UR_POSTED;
	localparam SRC_UR_NP   = `CER_BIT_UR_NP;
	localparam NSRC        = `CER_NUM_CLASS;

	wire cto_cor;
	wire cto_unc;
	wire ca;
	wire uc;
	wire ur_p;
	wire ur_np;
	wire log_req;
	wire any_hdr_err;

	// Each sampled high cycle is one event; no edge detect, so back-to-back
	// pulses of the same bit count as two distinct errors
	assign cto_cor = cpl_err_report[`CER_BIT_CTO_COR];              // R17 R3
	assign cto_unc = cpl_err_report[`CER_BIT_CTO_UNC];              // R5
	assign ca      = cpl_err_report[`CER_BIT_CA];                   // R7 R8
	assign uc      = cpl_err_report[`CER_BIT_UC] | tl_uc_detect;    // R9 R14
	assign ur_p    = cpl_err_report[`CER_BIT_UR_POSTED] | tl_ur_posted; // R10 R14
	assign ur_np   = cpl_err_report[`CER_BIT_UR_NP] | tl_ur_np;     // R11 R14
	assign log_req = cpl_err_report[`CER_BIT_LOG_HDR];
	assign any_hdr_err = |cpl_err_report[`CER_BIT_UR_NP:`CER_BIT_CA]; // R15

	// Message code each source would send under the present control inputs.
	// Codes resolve when a message is loaded, so a control change while an
	// error is still queued applies to that error as well.
	wire [`CER_MSG_W-1:0]      np_code;   // CA, UC and non-posted UR
	wire [`CER_MSG_W-1:0]      unc_code;  // Uncorrectable timeout
	wire [NSRC*`CER_MSG_W-1:0] src_code;  // All codes, source 0 lowest

	assign np_code  = advisory_nf_en ? `CER_MSG_COR : `CER_MSG_NONFATAL;
	assign unc_code = cto_unc_fatal ? `CER_MSG_FATAL : `CER_MSG_NONFATAL;  // R6

	// Highest source index first in the concatenation
	assign src_code = {np_code,             // Non-posted UR
	                   `CER_MSG_NONFATAL,   // Posted UR is never advisory
	                   np_code,             // Unexpected completion
	                   np_code,             // Completer abort
	                   unc_code,            // Uncorrectable timeout, R6
	                   `CER_MSG_COR};       // Correctable timeout, R4

	// Per-source error, enable, queue state and take strobe
	wire [NSRC-1:0] src_hit;    // Raw error this cycle
	wire [NSRC-1:0] src_en;     // Device control lets it send a message
	wire [NSRC-1:0] src_event;  // Error that queues a message
	wire [NSRC-1:0] src_pend;   // Source has messages waiting
	wire [NSRC-1:0] src_ovf;    // Source dropped a message
	reg  [NSRC-1:0] src_take;   // Slot loads from this source
	wire            np_en;      // Enable for CA, UC and non-posted UR
	wire            unc_en;     // Enable for uncorrectable timeout

	assign src_hit[SRC_CTO_COR] = cto_cor;   // R4
	assign src_hit[SRC_CTO_UNC] = cto_unc;   // R6
	assign src_hit[SRC_CA]      = ca;
	assign src_hit[SRC_UC]      = uc;        // R14
	assign src_hit[SRC_UR_P]    = ur_p;      // R14
	assign src_hit[SRC_UR_NP]   = ur_np;     // R14

	// Each severity has its own reporting enable; UR needs its own on top
	assign np_en  = advisory_nf_en ? cor_report_en : nf_report_en;
	assign unc_en = cto_unc_fatal ? fatal_report_en : nf_report_en;

	assign src_en[SRC_CTO_COR] = cor_report_en;
	assign src_en[SRC_CTO_UNC] = unc_en;
	assign src_en[SRC_CA]      = np_en;
	assign src_en[SRC_UC]      = np_en;
	assign src_en[SRC_UR_P]    = nf_report_en & ur_report_en;
	assign src_en[SRC_UR_NP]   = np_en & ur_report_en;

	// Only enabled errors queue a message; status bits are set regardless
	assign src_event = src_hit & src_en;                             // R12

	// One counter per source keeps simultaneous errors apart
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_pend
			cer_pend u_pend (
				.clk_sys  (clk_sys),
				.rst      (rst),
				.event_in (src_event[gi]),                    // R2
				.take     (src_take[gi]),
				.pending  (src_pend[gi]),
				.overflow (src_ovf[gi])
			);
		end
	endgenerate

	assign queue_overflow = |src_ovf;

	// Output slot: one message register, so msg_code comes from a flop
	reg                  slot_full;  // Slot holds a message
	wire                 slot_free;  // Slot may load this cycle
	reg [`CER_MSG_W-1:0] pick_code;  // Code of the chosen source
	reg                  pick_any;   // Some source was chosen
	integer              si;

	assign slot_free = !slot_full || msg_ready;
	assign msg_valid = slot_full;

	// Fixed order, lowest source first: a flood on a low source can hold
	// back higher ones, accepted because error reports are rare
	always @* begin
		src_take  = {NSRC{1'b0}};
		pick_code = `CER_MSG_COR;
		pick_any  = 1'b0;
		for (si = NSRC - 1; si >= 0; si = si - 1) begin
			if (slot_free && src_pend[si]) begin
				src_take     = {NSRC{1'b0}};
				src_take[si] = 1'b1;
				pick_code    = src_code[si*`CER_MSG_W +: `CER_MSG_W];
				pick_any     = 1'b1;
			end
		end
	end

	// Hold the message until the sink takes it
	always @(posedge clk_sys) begin
		if (rst) begin
			slot_full <= 1'b0;
			msg_code  <= `CER_MSG_COR;
		end else if (slot_free) begin
			slot_full <= pick_any;
			if (pick_any)
				msg_code <= pick_code;                          // R4 R6
		end
	end

	// Status bits that this cycle's errors set
	reg  [`CER_ST_W-1:0] st_set;  // Bits to set
	wire [`CER_ST_W-1:0] st_clr;  // Bits to clear
	wire                 np_err;  // Error whose severity follows advisory mode

	assign np_err = ca | uc | ur_np;
	assign st_clr = status_clear ? status_clear_mask : {`CER_ST_W{1'b0}};

	always @* begin
		st_set = {`CER_ST_W{1'b0}};
		st_set[`CER_ST_CED]  = cto_cor | (advisory_nf_en & np_err);
		st_set[`CER_ST_NFED] = (cto_unc & !cto_unc_fatal) | ur_p | (!advisory_nf_en & np_err);
		st_set[`CER_ST_FED]  = cto_unc & cto_unc_fatal;
		st_set[`CER_ST_URD]  = ur_p | ur_np;
		st_set[`CER_ST_CTO]  = cto_cor | cto_unc;
		st_set[`CER_ST_CA]   = ca;
		st_set[`CER_ST_UC]   = uc;
	end

	// Set wins over a clear in the same cycle so no error goes unseen
	always @(posedge clk_sys) begin
		if (rst)
			err_status <= {`CER_ST_W{1'b0}};
		else
			err_status <= (err_status & ~st_clr) | st_set;     // R12 R2
	end

	// First-error header log; a capture needs the log empty or being released
	wire log_capture;

	assign log_capture = log_req & any_hdr_err & (!hdr_log_valid | hdr_log_release); // R16

	always @(posedge clk_sys) begin
		if (rst) begin
			hdr_log       <= {`CER_HDR_W{1'b0}};
			hdr_log_valid <= 1'b0;
		end else if (log_capture) begin
			hdr_log       <= error_header_descriptor;       // R16
			hdr_log_valid <= 1'b1;
		end else if (hdr_log_release) begin
			hdr_log_valid <= 1'b0;
		end
	end

endmodule // cer_top

`default_nettype wire

// ==== cer_top_assertions.sv ====
// Checker for the completion error sideband, bound to cer_top.
// Assumes one clock domain and a message sink that may stall.
`timescale 1ns/1ps
`default_nettype none
`include "cer_defs.vh"
module cer_top_chk (
	input wire logic         clk_sys,
	input wire logic         rst,
	input wire logic [6:0]   cpl_err_report,
	input wire logic         hdr_log_release,
	input wire logic         msg_ready,
	input wire logic         msg_valid,
	input wire logic [1:0]   msg_code,
	input wire logic [6:0]   err_status,
	input wire logic [127:0] hdr_log,
	input wire logic         hdr_log_valid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// A stalled message must stay put
	AST_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_code)) else $error("message lost");
	AST_COR_MSG: assert property (cpl_err_report[0] |-> ##[1:200] (msg_valid && msg_ready
		&& msg_code == `CER_MSG_COR)) else $error("no advisory message");
	AST_CED: assert property (cpl_err_report[0] |-> ##[1:3] err_status[`CER_ST_CED]) else $error("no CED");
	AST_CTO: assert property (cpl_err_report[1] |-> ##[1:3] err_status[`CER_ST_CTO]) else $error("no CTO");
	AST_CA: assert property (cpl_err_report[2] |-> ##[1:3] err_status[`CER_ST_CA]) else $error("no CA");
	AST_UC: assert property (cpl_err_report[3] |-> ##[1:3] err_status[`CER_ST_UC]) else $error("no UC");
	AST_URD: assert property (|cpl_err_report[5:4] |-> ##[1:3] err_status[`CER_ST_URD]) else $error("no URD");
	// Only the first logged header survives
	AST_LOG_KEEP: assert property (hdr_log_valid && !hdr_log_release |=> $stable(hdr_log)) else $error("log moved");
	AST_LOG_SET: assert property (cpl_err_report[6] && |cpl_err_report[5:2] && !hdr_log_valid
		|-> ##[1:3] hdr_log_valid) else $error("no log");
	cover property (msg_valid && msg_ready);
	cover property ($rose(hdr_log_valid));
	cover property (cpl_err_report[2] && cpl_err_report[5]);
endmodule // cer_top_chk
bind cer_top cer_top_chk cer_top_chk_inst (.clk_sys(clk_sys), .rst(rst), .cpl_err_report(cpl_err_report),
	.hdr_log_release(hdr_log_release), .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_code(msg_code),
	.err_status(err_status), .hdr_log(hdr_log), .hdr_log_valid(hdr_log_valid));
`default_nettype wire

// ==== cer_app.sv ====
// Application-side model: error pulses and a stalling message sink.
// Assumes the bench asks via fire for one cycle per event.
`timescale 1ns/1ps
`default_nettype none
module cer_app (
	input wire logic        clk_sys, // Clock
	input wire logic        fire,    // Report request
	input wire logic [6:0]  req,     // Error bits
	input wire logic        stall,   // Sink busy
	output var logic [6:0]  rep,     // To device
	output var logic        rdy      // Sink ready
);
	// One high cycle per event, several bits may share it
	always @(posedge clk_sys) begin
		rep <= fire ? req : 7'h00;
		rdy <= !stall;
	end
endmodule // cer_app
`default_nettype wire

// ==== tb_cer_top.sv ====
// Bench for cer_top: drives error events, checks messages, status and log.
// Assumes cer_app as the application and sink.
`timescale 1ns/1ps
`default_nettype none
`include "cer_defs.vh"
module tb_cer_top;
	logic clk_sys = 0, rst = 1, fire = 0, stall = 0, tuc = 0, tup = 0, tun = 0, cfat = 0, clr = 0, rel = 0, adv = 0;
	logic [6:0] req = 0, rep, mask = 0, st;
	logic [127:0] hdr = 0, hlog;
	logic [1:0] code;
	logic rdy, vld, hv, ovf;
	logic [1:0] exp[$];
	integer seed = 32'hffedd8de, err_total = 0, n_checks = 0, i, k, w;
	always #5 clk_sys = ~clk_sys;
	cer_app cer_app_inst (.clk_sys(clk_sys), .fire(fire), .req(req), .stall(stall), .rep(rep), .rdy(rdy));
	cer_top cer_top_inst (.clk_sys(clk_sys), .rst(rst), .cpl_err_report(rep), .error_header_descriptor(hdr),
		.tl_uc_detect(tuc), .tl_ur_posted(tup), .tl_ur_np(tun), .advisory_nf_en(adv), .cto_unc_fatal(cfat),
		.ur_report_en(1'b1), .cor_report_en(1'b1), .nf_report_en(1'b1), .fatal_report_en(1'b1),
		.status_clear(clr), .status_clear_mask(mask), .hdr_log_release(rel), .msg_ready(rdy), .msg_valid(vld),
		.msg_code(code), .err_status(st), .hdr_log(hlog), .hdr_log_valid(hv), .queue_overflow(ovf));
	task chk(input logic [127:0] s, input logic [127:0] e); begin
		n_checks = n_checks + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("[ERR] %0t saw %h want %h", $time, s, e);
		end
	end endtask
	task results; begin
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	end endtask
	task send(input logic [6:0] v); begin
		@(posedge clk_sys); #1 req = v; fire = 1;
		@(posedge clk_sys); #1 fire = 0;
	end endtask
	task drain(input integer t); begin
		for (i = 0; i < 400 && exp.size() > 0; i++) @(posedge clk_sys);
		#1 chk(exp.size(), 0);
		$display("test %0d done", t);
	end endtask
	// Random sink stalls
	always @(posedge clk_sys) #1 stall = ($random(seed) & 3) == 0;
	// Each taken message is matched to the oldest note
	always @(posedge clk_sys) if (!rst && vld === 1'b1 && rdy === 1'b1) begin
		if (exp.size() > 0) chk(code, exp.pop_front());
		else chk(code, 2'bxx);
	end
	initial begin #300000; err_total = err_total + 1; results; end
	initial begin
		repeat (5) @(posedge clk_sys);
		#1 rst = 0;
		for (k = 0; k < 6; k++) begin exp.push_back(k == 0 ? `CER_MSG_COR : `CER_MSG_NONFATAL); send(7'h01 << k); end
		drain(1);
		for (k = 0; k < 20; k++) begin
			i = ($random(seed) & 32'h7FFFFFFF) % 6;
			exp.push_back(i == 0 ? `CER_MSG_COR : `CER_MSG_NONFATAL);
			send(7'h01 << i);
			// One at a time: the design serves sources in fixed order, not arrival
			for (w = 0; w < 50 && exp.size() > 0; w++) @(posedge clk_sys);
		end
		drain(2);
		repeat (3) exp.push_back(`CER_MSG_NONFATAL);
		send(7'h2C);
		drain(3);
		cfat = 1;
		exp.push_back(`CER_MSG_FATAL);
		send(7'h02);
		repeat (3) exp.push_back(`CER_MSG_NONFATAL);
		@(posedge clk_sys); #1 tuc = 1; tup = 1; tun = 1;
		@(posedge clk_sys); #1 tuc = 0; tup = 0; tun = 0;
		drain(4);
		adv = 1;
		exp.push_back(`CER_MSG_COR);
		send(7'h04);
		drain(5);
		adv = 0;
		hdr = {4{32'hA5C3_0F1E}};
		exp.push_back(`CER_MSG_NONFATAL);
		send(7'h44);
		@(posedge clk_sys); #1 hdr = {4{32'h1234_5678}};
		exp.push_back(`CER_MSG_NONFATAL);
		send(7'h48);
		drain(6);
		chk(hlog, {4{32'hA5C3_0F1E}});
		chk(hv, 1'b1);
		chk(st, 7'h7F);
		chk(ovf, 1'b0);
		@(posedge clk_sys); #1 clr = 1; mask = 7'h7F; rel = 1;
		@(posedge clk_sys); #1 clr = 0; rel = 0;
		repeat (3) @(posedge clk_sys);
		#1 chk(st, 7'h00);
		chk(hv, 1'b0);
		results;
	end
endmodule // tb_cer_top
`default_nettype wire
